// ### rtl/pfc_consts.vh
// Constants for the parallel flash command controller
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH
`define PFC_CLK_MHZ        25
`define PFC_ADDR_UNLOCK1   16'h5555
`define PFC_ADDR_UNLOCK2   16'h2AAA
`define PFC_ADDR_LOCKSTAT  16'h0002
`define PFC_ADDR_MANUF     16'h0000
`define PFC_ADDR_DEVICE    16'h0001
`define PFC_DATA_UNLOCK1   8'hAA
`define PFC_DATA_UNLOCK2   8'h55
`define PFC_DATA_SETUP     8'h80
`define PFC_DATA_CHIPERS   8'h10
`define PFC_DATA_MAINERS   8'h30
`define PFC_DATA_PROGRAM   8'hA0
`define PFC_DATA_LOCKOUT   8'h40
`define PFC_DATA_IDENTRY   8'h90
`define PFC_DATA_IDEXIT    8'hF0
`define PFC_OP_READ        3'h0
`define PFC_OP_PROGRAM     3'h1
`define PFC_OP_CHIPERS     3'h2
`define PFC_OP_MAINERS     3'h3
`define PFC_OP_LOCKOUT     3'h4
`define PFC_OP_IDENTRY     3'h5
`define PFC_OP_IDEXIT      3'h6
`define PFC_OP_IDEXIT1     3'h7
`define PFC_STROBE_NS      80
`define PFC_STROBE_CYC     ((`PFC_STROBE_NS * `PFC_CLK_MHZ + 999) / 1000)
`define PFC_POLL_LIMIT     32'h0FFFFFFF
`endif

// ### rtl/pfc_bus_cycle.v
// One strobed bus cycle on the flash pins, write or read
`timescale 1ns/100ps
`include "pfc_consts.vh"
module pfc_bus_cycle (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        start,
   input  wire        is_write,
   input  wire [15:0] addr,
   input  wire [15:0] wdata,
   input  wire [15:0] data_bus_in,
   output reg  [15:0] rdata,
   output reg         done,
   output reg  [15:0] address_bus,
   output reg  [15:0] data_bus_out,
   output reg         data_bus_oe,
   output reg         chip_select_n,
   output reg         output_drive_n,
   output reg         write_strobe_n
);
   localparam S_IDLE = 2'd0;
   localparam S_SET  = 2'd1;
   localparam S_STRB = 2'd2;
   localparam S_HOLD = 2'd3;
   // Strobe length in cycles, cut to the counter width on purpose
   localparam [31:0] STROBE_CYC = `PFC_STROBE_CYC;
   reg [1:0] state_r;
   reg [3:0] cnt_r;
   reg       wr_r;

   // Address settles a cycle before the strobe; strobe held long enough
   // to pass the device noise filter; data held one cycle past release
   always @(posedge clk_sys) begin
      done <= 1'b0;
      if (rst) begin
         state_r        <= S_IDLE;
         cnt_r          <= 4'h0;
         wr_r           <= 1'b0;
         rdata          <= 16'h0000;
         address_bus    <= 16'h0000;
         data_bus_out   <= 16'h0000;
         data_bus_oe    <= 1'b0;
         chip_select_n  <= 1'b1;
         output_drive_n <= 1'b1;
         write_strobe_n <= 1'b1;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (start) begin
                  address_bus   <= addr;
                  data_bus_out  <= wdata;
                  wr_r          <= is_write;
                  data_bus_oe   <= is_write;
                  chip_select_n <= 1'b0;
                  state_r       <= S_SET;
               end
            end
            S_SET: begin
               // Output drive stays high on writes to avoid inhibit
               if (wr_r)
                  write_strobe_n <= 1'b0; // RULE_21 RULE_11
               else
                  output_drive_n <= 1'b0;
               cnt_r   <= STROBE_CYC[3:0];
               state_r <= S_STRB;
            end
            S_STRB: begin
               if (cnt_r <= 4'h1) begin
                  if (!wr_r)
                     rdata <= data_bus_in;
                  write_strobe_n <= 1'b1; // RULE_22
                  output_drive_n <= 1'b1; // RULE_02
                  state_r        <= S_HOLD;
               end else
                  cnt_r <= cnt_r - 4'h1;
            end
            S_HOLD: begin
               chip_select_n <= 1'b1;
               data_bus_oe   <= 1'b0;
               done          <= 1'b1;
               state_r       <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule // pfc_bus_cycle

// ### rtl/pfc_flash_ctrl.v
// Host controller that sequences commands to a parallel 64K x 16 flash
`timescale 1ns/100ps
`include "pfc_consts.vh"
// Contract
// RULE_01: Device drives addressed word when selected, output enabled, no write.
// RULE_02: Device floats data when select or output enable high.
// RULE_03: Unlocked chip erase clears boot and main regions.
// RULE_04: Locked chip erase keeps boot region, clears main.
// RULE_05: Device returns to read after chip erase.
// RULE_06: Main erase sets every non-boot word to all ones.
// RULE_07: Main erase is six writes, last at 5555 with 30.
// RULE_08: Main erase starts after sixth strobe rise, self-timed.
// RULE_09: Program only clears bits; ones need an erase.
// RULE_10: Word program is four writes; device times the pulses.
// RULE_11: Address latched on later falling edge, data on earlier rise.
// RULE_12: Program completes within program_time_limit after last write.
// RULE_13: Boot region is 8K words starting at word zero.
// RULE_14: Lockout forbids boot changes forever; main still works.
// RULE_15: Host activates lockout by six defined command writes.
// RULE_16: In ID mode address 0002 bit 0 shows lockout state.
// RULE_17: Host issues ID exit after reading ID or lockout.
// RULE_18: Hardware and software ID give identical codes.
// RULE_19: During program, bit 7 reads inverted until done.
// RULE_20: Bit 6 toggles on successive reads while busy.
// RULE_21: No program cycle with output enable low or strobes high.
// RULE_22: Strobes shorter than noise threshold are ignored.
// RULE_23: Only data bits 7 to 0 carry the command byte.
// RULE_24: Top address bit is ignored in command decode.
// RULE_25: Either three-write or single-write ID exit is accepted.
// RULE_26: Host waits for completion by polling before next command.
module pfc_flash_ctrl (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        cmd_valid,
   input  wire [2:0]  cmd_op,
   input  wire [15:0] cmd_addr,
   input  wire [15:0] cmd_data,
   output wire        cmd_ready,
   output reg         rsp_valid,
   output reg  [15:0] rsp_data,
   output reg         rsp_timeout,
   output wire [15:0] address_bus,
   input  wire [15:0] data_bus_in,
   output wire [15:0] data_bus_out,
   output wire        data_bus_oe,
   output wire        chip_select_n,
   output wire        output_drive_n,
   output wire        write_strobe_n
);
   localparam S_IDLE  = 3'd0;
   localparam S_WRITE = 3'd1;
   localparam S_WWAIT = 3'd2;
   localparam S_POLL  = 3'd3;
   localparam S_PWAIT = 3'd4;
   localparam S_READ  = 3'd5;
   localparam S_RWAIT = 3'd6;

   reg [2:0]  state_r;
   reg [2:0]  op_r;
   reg [15:0] addr_r;
   reg [15:0] data_r;
   reg [2:0]  step_r;
   reg [2:0]  nsteps_r;
   reg        first_poll_r;
   reg        last6_r;
   reg [31:0] poll_cnt_r;
   reg        bc_start;
   reg        bc_write;
   reg [15:0] bc_addr;
   reg [15:0] bc_wdata;
   wire [15:0] bc_rdata;
   wire        bc_done;

   assign cmd_ready = (state_r == S_IDLE);

   // Final byte of a six-write erase or lockout sequence
   function [7:0] last_byte;
      input [2:0] op;
      begin
         case (op)
            `PFC_OP_CHIPERS: last_byte = `PFC_DATA_CHIPERS; // RULE_03
            `PFC_OP_MAINERS: last_byte = `PFC_DATA_MAINERS; // RULE_07
            default:         last_byte = `PFC_DATA_LOCKOUT; // RULE_15
         endcase
      end
   endfunction

   // Address and data of each write step; upper data byte sent as zero except in the program data word
   always @* begin
      bc_addr  = `PFC_ADDR_UNLOCK1;
      bc_wdata = 16'h0000; // RULE_23
      case (step_r)
         3'd0: bc_wdata[7:0] = (op_r == `PFC_OP_IDEXIT1) ?
                               `PFC_DATA_IDEXIT : `PFC_DATA_UNLOCK1;
         3'd1: begin
            bc_addr       = `PFC_ADDR_UNLOCK2;
            bc_wdata[7:0] = `PFC_DATA_UNLOCK2;
         end
         3'd2: begin
            case (op_r)
               `PFC_OP_PROGRAM: bc_wdata[7:0] = `PFC_DATA_PROGRAM; // RULE_10
               `PFC_OP_IDENTRY: bc_wdata[7:0] = `PFC_DATA_IDENTRY;
               `PFC_OP_IDEXIT:  bc_wdata[7:0] = `PFC_DATA_IDEXIT; // RULE_25
               default:         bc_wdata[7:0] = `PFC_DATA_SETUP;
            endcase
         end
         3'd3: begin
            if (op_r == `PFC_OP_PROGRAM) begin
               bc_addr  = addr_r; // Full word for program data
               bc_wdata = data_r;
            end else
               bc_wdata[7:0] = `PFC_DATA_UNLOCK1;
         end
         3'd4: begin
            bc_addr       = `PFC_ADDR_UNLOCK2;
            bc_wdata[7:0] = `PFC_DATA_UNLOCK2;
         end
         default: bc_wdata[7:0] = last_byte(op_r);
      endcase
      // The bus cycle takes the address one edge after start, when the
      // sequencer already waits, so the wait states must keep it too
      if (state_r == S_POLL || state_r == S_PWAIT ||
          state_r == S_READ || state_r == S_RWAIT)
         bc_addr = addr_r;
   end

   // Command sequencer: writes, then polls for completion where needed
   always @(posedge clk_sys) begin
      bc_start  <= 1'b0;
      rsp_valid <= 1'b0;
      if (rst) begin
         state_r      <= S_IDLE;
         op_r         <= `PFC_OP_READ;
         addr_r       <= 16'h0000;
         data_r       <= 16'h0000;
         step_r       <= 3'd0;
         nsteps_r     <= 3'd0;
         first_poll_r <= 1'b0;
         last6_r      <= 1'b0;
         poll_cnt_r   <= 32'h00000000;
         bc_write     <= 1'b0;
         rsp_data     <= 16'h0000;
         rsp_timeout  <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (cmd_valid) begin
                  op_r        <= cmd_op;
                  addr_r      <= cmd_addr;
                  data_r      <= cmd_data;
                  step_r      <= 3'd0;
                  rsp_timeout <= 1'b0;
                  case (cmd_op)
                     `PFC_OP_READ:    nsteps_r <= 3'd0;
                     `PFC_OP_PROGRAM: nsteps_r <= 3'd4;
                     `PFC_OP_IDENTRY: nsteps_r <= 3'd3;
                     `PFC_OP_IDEXIT:  nsteps_r <= 3'd3; // RULE_17
                     `PFC_OP_IDEXIT1: nsteps_r <= 3'd1; // RULE_17
                     default:         nsteps_r <= 3'd6;
                  endcase
                  state_r <= (cmd_op == `PFC_OP_READ) ? S_READ : S_WRITE;
               end
            end
            S_WRITE: begin
               bc_start <= 1'b1;
               bc_write <= 1'b1;
               state_r  <= S_WWAIT;
            end
            S_WWAIT: begin
               if (bc_done) begin
                  if (step_r == nsteps_r - 3'd1) begin
                     poll_cnt_r   <= 32'h00000000;
                     first_poll_r <= 1'b1;
                     // Busy only after program, erase or lockout
                     if (op_r == `PFC_OP_IDENTRY ||
                         op_r == `PFC_OP_IDEXIT  ||
                         op_r == `PFC_OP_IDEXIT1) begin
                        rsp_valid <= 1'b1;
                        state_r   <= S_IDLE;
                     end else
                        state_r <= S_POLL; // RULE_26
                  end else begin
                     step_r  <= step_r + 3'd1;
                     state_r <= S_WRITE;
                  end
               end
            end
            S_POLL: begin
               bc_start <= 1'b1;
               bc_write <= 1'b0;
               state_r  <= S_PWAIT;
            end
            S_PWAIT: begin
               if (bc_done) begin
                  first_poll_r <= 1'b0;
                  last6_r      <= bc_rdata[6];
                  poll_cnt_r   <= poll_cnt_r + 32'h00000001;
                  // Done once bit 6 stops toggling between two reads
                  if (!first_poll_r && bc_rdata[6] == last6_r) begin // RULE_20
                     rsp_data  <= bc_rdata;
                     rsp_valid <= 1'b1;
                     state_r   <= S_IDLE;
                  end else if (poll_cnt_r >= `PFC_POLL_LIMIT) begin // RULE_12
                     rsp_data    <= bc_rdata;
                     rsp_timeout <= 1'b1;
                     rsp_valid   <= 1'b1;
                     state_r     <= S_IDLE;
                  end else
                     state_r <= S_POLL;
               end
            end
            S_READ: begin
               bc_start <= 1'b1;
               bc_write <= 1'b0;
               state_r  <= S_RWAIT;
            end
            S_RWAIT: begin
               if (bc_done) begin
                  rsp_data  <= bc_rdata; // RULE_01
                  rsp_valid <= 1'b1;
                  state_r   <= S_IDLE;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Pin-level strobe generator
   pfc_bus_cycle u_cycle (
      .clk_sys        (clk_sys),
      .rst            (rst),
      .start          (bc_start),
      .is_write       (bc_write),
      .addr           (bc_addr),
      .wdata          (bc_wdata),
      .data_bus_in    (data_bus_in),
      .rdata          (bc_rdata),
      .done           (bc_done),
      .address_bus    (address_bus),
      .data_bus_out   (data_bus_out),
      .data_bus_oe    (data_bus_oe),
      .chip_select_n  (chip_select_n),
      .output_drive_n (output_drive_n),
      .write_strobe_n (write_strobe_n)
   );
endmodule // pfc_flash_ctrl

// ### verification/pfc_flash_model.sv
// Behavioural model of the parallel flash behind the controller
`timescale 1ns/100ps
module pfc_flash_model #(
   parameter MFR_CODE = 16'h00A1, // Arbitrary identity value
   parameter DEV_CODE = 16'h00B2, // Arbitrary identity value
   parameter PROG_NS  = 1000,
   parameter ERASE_NS = 4000
) (
   input  wire        clk_sys,
   input  wire [15:0] address_bus,
   input  wire [15:0] data_bus_out,
   input  wire        data_bus_oe,
   input  wire        chip_select_n,
   input  wire        output_drive_n,
   input  wire        write_strobe_n,
   output wire [15:0] data_bus_in
);
   reg [15:0] mem [0:65535];
   reg [15:0] la, lw, q;
   reg [2:0]  st;
   reg        pg, idm, lk, bsy, tog, ers;
   realtime   t_end, t_f;
   integer    i;
   wire [7:0]  d = data_bus_out[7:0];
   wire [14:0] a = la[14:0];
   // Erase wipes the array at once; busy time is only modelled
   task wipe(input all);
      begin
         for (i = 0; i < 65536; i = i + 1)
            if (all || i >= 16'h2000) mem[i] = 16'hFFFF;
         ers = 1;
         t_end = $realtime + ERASE_NS;
      end
   endtask
   initial begin
      for (i = 0; i < 65536; i = i + 1) mem[i] = {i[7:0], ~i[15:8]};
      {st, pg, idm, lk, bsy, tog, ers} = 0;
      t_end = 0;
   end
   // Address is taken at the strobe fall, after select is already low
   always @(negedge write_strobe_n) begin
      t_f = $realtime;
      if (!chip_select_n) la = address_bus;
   end
   // Commands act at the strobe rise; short or inhibited pulses do nothing
   always @(posedge write_strobe_n)
      if (!chip_select_n && output_drive_n && $realtime - t_f >= 15) begin
         if (pg) begin
            if (!(lk && la < 16'h2000)) begin
               mem[la] = mem[la] & data_bus_out;
               lw = la;
               ers = 0;
               t_end = $realtime + PROG_NS;
            end
            pg = 0;
         end else if (d == 8'hF0) begin
            idm = 0;
            st = 0;
         end else case (st)
            0, 3: st = (a == 15'h5555 && d == 8'hAA) ? st + 1 : 0;
            1, 4: st = (a == 15'h2AAA && d == 8'h55) ? st + 1 : 0;
            2: begin
               pg = (d == 8'hA0);
               if (d == 8'h90) idm = 1;
               st = (d == 8'h80) ? 3 : 0;
            end
            default: begin
               if (d == 8'h10) wipe(!lk);
               if (d == 8'h30) wipe(0);
               if (d == 8'h40) lk = 1;
               st = 0;
            end
         endcase
      end
   // Each read while busy flips the toggle bit
   always @(negedge output_drive_n) begin
      bsy = ($realtime < t_end);
      if (bsy) tog = ~tog;
   end
   // Read word prepared at mid-cycle, well before the controller samples
   always @(negedge clk_sys) begin
      q = mem[address_bus];
      if (idm) q = address_bus[1] ? {15'h0, lk} : address_bus[0] ?
                   DEV_CODE : MFR_CODE;
      if (bsy) q[6] = tog;
      if (bsy && !ers && address_bus == lw) q[7] = ~q[7];
   end
   // Released lines flip every half clock so stale data cannot pass
   assign data_bus_in = data_bus_oe ? data_bus_out :
      (!chip_select_n && !output_drive_n) ? q :
      {16{clk_sys}} ^ 16'h5A5A;
endmodule // pfc_flash_model

// ### verification/pfc_flash_ctrl_checker.sv
// Port assertions for the flash command controller
`timescale 1ns/100ps
module pfc_flash_ctrl_checker (
   input wire        clk_sys,
   input wire        rst,
   input wire        cmd_valid,
   input wire [2:0]  cmd_op,
   input wire        cmd_ready,
   input wire        rsp_valid,
   input wire [15:0] address_bus,
   input wire [15:0] data_bus_out,
   input wire        data_bus_oe,
   input wire        chip_select_n,
   input wire        output_drive_n,
   input wire        write_strobe_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_reset_idle: assert property (disable iff (1'b0) rst |=> chip_select_n
      && write_strobe_n && output_drive_n && !data_bus_oe)
      else $error("pins not idle after reset");
   a_write_inhibit: assert property (!write_strobe_n |->
      !chip_select_n && output_drive_n) else $error("write not qualified");
   a_strobe_width: assert property ($fell(write_strobe_n) |=>
      !write_strobe_n ##1 write_strobe_n) else $error("bad strobe width");
   a_read_width: assert property ($fell(output_drive_n) |=>
      !output_drive_n ##1 output_drive_n) else $error("bad read width");
   a_write_hold: assert property (!write_strobe_n |-> data_bus_oe &&
      $stable(address_bus) && $stable(data_bus_out))
      else $error("write lines moved");
   a_cs_after_we: assert property ($rose(write_strobe_n) |=>
      chip_select_n) else $error("select not released after strobe");
   a_cmd_byte: assert property (!write_strobe_n &&
      address_bus == 16'h2AAA |-> data_bus_out == 16'h0055)
      else $error("bad unlock word");
   a_no_contend: assert property (!output_drive_n |->
      !data_bus_oe) else $error("host drives during read");
   a_read_lat: assert property (cmd_valid && cmd_ready &&
      cmd_op == 3'h0 |-> ##[7:9] rsp_valid) else $error("read late");
   a_one_cmd: assert property (cmd_valid && cmd_ready |=>
      !cmd_ready) else $error("second command taken");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("response longer than one cycle");
   c_main_erase: cover property (!write_strobe_n &&
      address_bus == 16'h5555 && data_bus_out == 16'h0030);
   c_lockout: cover property (!write_strobe_n &&
      address_bus == 16'h5555 && data_bus_out == 16'h0040);
   c_read: cover property (!output_drive_n ##3 rsp_valid);
endmodule // pfc_flash_ctrl_checker

// ### verification/pfc_flash_ctrl_tb_top.sv
// Self-checking bench for the flash command controller
`timescale 1ns/100ps
module pfc_flash_ctrl_tb_top;
   localparam MFR = 16'h00A1; // Arbitrary identity value
   localparam DEV = 16'h00B2; // Arbitrary identity value
   localparam N   = 17'h00000; // Response word not checked
   reg         clk_sys = 0, rst = 1, cmd_valid = 0;
   reg  [2:0]  cmd_op = 0;
   reg  [15:0] cmd_addr = 0, cmd_data = 0, b, m;
   wire        cmd_ready, rsp_valid, rsp_timeout, data_bus_oe;
   wire        chip_select_n, output_drive_n, write_strobe_n;
   wire [15:0] rsp_data, address_bus, data_bus_in, data_bus_out;
   reg  [15:0] sh [0:65535];
   reg  [16:0] q [$];
   reg  [16:0] e;
   reg  [31:0] r;
   integer     n_mismatch = 0, compares = 0, cyc = 0, i;
   always #20 clk_sys = ~clk_sys;
   pfc_flash_ctrl dut (.clk_sys, .rst, .cmd_valid, .cmd_op, .cmd_addr,
      .cmd_data, .cmd_ready, .rsp_valid, .rsp_data, .rsp_timeout,
      .address_bus, .data_bus_in, .data_bus_out, .data_bus_oe,
      .chip_select_n, .output_drive_n, .write_strobe_n);
   pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.clk_sys,
      .address_bus, .data_bus_out, .data_bus_oe, .chip_select_n,
      .output_drive_n, .write_strobe_n, .data_bus_in);
   task cmp16(input [15:0] g, input [15:0] x);
      begin
         compares = compares + 1;
         if (g !== x) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t word %h not %h", $time, g, x);
         end
      end
   endtask
   task cmp1(input g, input x);
      begin
         compares = compares + 1;
         if (g !== x) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t flag %b not %b", $time, g, x);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("compares %0d mismatches %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // One command: note the expected word, then wait for its answer
   task cmd(input [2:0] op, input [15:0] a, input [15:0] d, input [16:0] x);
      integer k;
      begin
         @(posedge clk_sys) #1;
         // Ready only moves on edges, so looking just after one is safe
         while (cmd_ready !== 1'b1) @(posedge clk_sys) #1;
         {cmd_valid, cmd_op, cmd_addr, cmd_data} = {1'b1, op, a, d};
         q.push_back(x);
         @(posedge clk_sys) #1 cmd_valid = 0;
         for (k = 0; k < 3000 && q.size() > 0; k = k + 1) @(posedge clk_sys);
         if (q.size() > 0) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t no answer to command %h", $time, op);
            q.delete();
         end
      end
   endtask
   task rd(input [15:0] a);
      cmd(3'h0, a, 16'h0000, {1'b1, sh[a]});
   endtask
   task pg(input [15:0] a, input [15:0] d);
      begin
         sh[a] = sh[a] & d;
         cmd(3'h1, a, d, {1'b1, sh[a]});
      end
   endtask
   task wipe(input all);
      for (i = 0; i < 65536; i = i + 1)
         if (all || i >= 16'h2000) sh[i] = 16'hFFFF;
   endtask
   // Watcher takes the oldest note for each answer; also bounds the run
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc > 40000) begin
         n_mismatch = n_mismatch + 1;
         report_and_stop;
      end else if (rsp_valid === 1'b1) begin
         cmp1(rsp_timeout, 1'b0);
         if (q.size() == 0) cmp1(1'b1, 1'b0);
         else begin
            e = q.pop_front();
            if (e[16]) cmp16(rsp_data, e[15:0]);
         end
      end
   end
   initial begin
      for (i = 0; i < 65536; i = i + 1) sh[i] = {i[7:0], ~i[15:8]};
      r = $urandom(48733);
      repeat (8) @(posedge clk_sys);
      #1 rst = 0;
      r = $urandom;
      b = {3'h0, r[12:0]};
      m = {3'h4, r[28:16]};
      rd(b);
      cmd(3'h2, 16'h0000, 16'h0000, N);
      wipe(1);
      rd(b);
      rd(m);
      r = $urandom;
      pg(b, r[15:0]);
      pg(b, r[31:16]);
      pg(16'h1FFF, 16'h0000);
      pg(m, r[15:0]);
      cmd(3'h5, 16'h0000, 16'h0000, N);
      cmd(3'h0, 16'h0000, 16'h0000, {1'b1, MFR});
      cmd(3'h0, 16'h0001, 16'h0000, {1'b1, DEV});
      cmd(3'h0, 16'h0002, 16'h0000, 17'h10000);
      cmd(3'h6, 16'h0000, 16'h0000, N);
      rd(16'h0002);
      cmd(3'h4, 16'h0000, 16'h0000, N);
      cmd(3'h5, 16'h0000, 16'h0000, N);
      cmd(3'h0, 16'h0002, 16'h0000, 17'h10001);
      cmd(3'h7, 16'h0000, 16'h0000, N);
      rd(16'h0002);
      cmd(3'h1, b, 16'h0000, {1'b1, sh[b]});
      rd(b);
      pg(16'h2000, 16'h0000);
      cmd(3'h3, 16'h0000, 16'h0000, N);
      wipe(0);
      rd(b);
      rd(16'h1FFF);
      rd(16'h2000);
      pg(m, r[31:16]);
      cmd(3'h2, 16'h0000, 16'h0000, N);
      wipe(0);
      rd(b);
      rd(m);
      report_and_stop;
   end
endmodule // pfc_flash_ctrl_tb_top
bind pfc_flash_ctrl pfc_flash_ctrl_checker u_chk (.clk_sys, .rst,
   .cmd_valid, .cmd_op, .cmd_ready, .rsp_valid, .address_bus,
   .data_bus_out, .data_bus_oe, .chip_select_n, .output_drive_n,
   .write_strobe_n);
